// ==== hdl/tsc_pkg.sv ====
// Purpose: Shared constants and types of the thermal sensor control/status block
// Assumes: 100 MHz system clock
// Notes: Command bytes are the register addresses seen on the two-wire bus
package tsc_pkg;
	// Clock and timing
	localparam int CLK_FREQ_HZ = 100_000_000;
	localparam int PWRUP_TIME_MS = 30;
	localparam int PWRUP_CYCLES = PWRUP_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam logic [7:0] CONV_CYCLES = 8'h40;
	// Bus address of this device (arbitrary)
	localparam logic [6:0] DEV_ADDR = 7'h18;
	// Command bytes
	localparam logic [7:0] CMD_COMMON_STATUS = 8'h02;
	localparam logic [7:0] CMD_CONFIG = 8'h03;
	localparam logic [7:0] CMD_FILTER = 8'h06;
	localparam logic [7:0] CMD_FAULT = 8'h07;
	localparam logic [7:0] CMD_STATUS_TWO = 8'h08;
	localparam logic [7:0] CMD_STATUS_THREE = 8'h09;
	localparam logic [7:0] CMD_STATUS_FOUR = 8'h0a;
	localparam logic [7:0] CMD_SINGLE_CONV = 8'h0f;
	// Reset values and writable masks
	localparam logic [7:0] FILTER_RESET = 8'h0f;
	localparam logic [7:0] FILTER_WR_MASK = 8'h0f;
	localparam logic [7:0] CONFIG_RESET = 8'h03;
	localparam logic [7:0] CONFIG_WR_MASK = 8'h43;
	localparam logic [7:0] COMMON_RESET = 8'h00;
	// Field positions
	localparam int FLT_R2_LSB = 2;
	localparam int FLT_R1_LSB = 0;
	localparam int CFG_STANDBY_BIT = 6;
	localparam int CS_BUSY_BIT = 7;
	localparam int CS_PENDING_BIT = 6;
	// Fault substitutes
	localparam logic [7:0] FAULT_UNSIGNED = 8'h00;
	localparam logic [7:0] FAULT_SIGNED = 8'h80;
	localparam logic [2:0] LAST_CHAN = 3'h4;
	typedef enum logic [0:0] {
		SEQ_IDLE = 1'b0,
		SEQ_RUN = 1'b1
	} tsc_seq_state_e;
	typedef enum logic [3:0] {
		BUS_IDLE = 4'h0,
		BUS_ADDR = 4'h1,
		BUS_ADDR_ACK = 4'h2,
		BUS_CMD = 4'h3,
		BUS_CMD_ACK = 4'h4,
		BUS_WDATA = 4'h5,
		BUS_WDATA_ACK = 4'h6,
		BUS_RDATA = 4'h7,
		BUS_RDATA_ACK = 4'h8
	} tsc_bus_state_e;
endpackage

// ==== hdl/tsc_conv_if.sv ====
// Purpose: Carrier between the register logic and the conversion sequencer
// Assumes: Single clock domain
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ns
`default_nettype none
interface tsc_conv_if;
	logic start;
	logic [4:0] enable;
	logic busy;
	logic done;
	modport ctrl (output start, output enable, input busy, input done);
	modport seq (input start, input enable, output busy, output done);
endinterface
`default_nettype wire

// ==== hdl/tsc_conv_seq.sv ====
// Purpose: Walks one conversion pass over local and four remote channels
// Assumes: Enables steady during a pass
// Notes: Disabled channels take one cycle, enabled ones CONV_CYCLES
`timescale 1ns/1ns
`default_nettype none
module tsc_conv_seq (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Control side
	tsc_conv_if.seq conv
);
	import tsc_pkg::*;

	tsc_seq_state_e state;
	logic [2:0] chan;
	logic [7:0] cnt;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state <= SEQ_IDLE;
			conv.busy <= 1'b0;
			conv.done <= 1'b0;
			chan <= 3'h0;
			cnt <= 8'h00;
		end else begin
			conv.done <= 1'b0;
			case (state)
				SEQ_IDLE: begin
					if (conv.start) begin
						state <= SEQ_RUN;
						conv.busy <= 1'b1;
						chan <= 3'h0;
						cnt <= 8'h00;
					end
				end
				SEQ_RUN: begin
					if (!conv.enable[chan] || cnt == CONV_CYCLES - 8'h01) begin
						cnt <= 8'h00;
						if (chan == LAST_CHAN) begin
							state <= SEQ_IDLE;
							conv.busy <= 1'b0;
							conv.done <= 1'b1;
						end else begin
							chan <= chan + 3'h1;
						end
					end else begin
						cnt <= cnt + 8'h01;
					end
				end
				default: begin
					state <= SEQ_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_skip_disabled: assert property (@(posedge i_clk) disable iff (i_srst)
		(state == SEQ_RUN && !conv.enable[chan] && chan != LAST_CHAN) |=> chan == $past(chan) + 3'h1)
		else $error("disabled channel not skipped");
	chk_busy_clear: assert property (@(posedge i_clk) disable iff (i_srst)
		conv.done |-> !conv.busy && $past(chan) == LAST_CHAN)
		else $error("busy not cleared at pass end");
	cov_full_pass: cover property (@(posedge i_clk) disable iff (i_srst) conv.done);
endmodule
`default_nettype wire

// ==== hdl/tsc_ctrl_status.sv ====
// Purpose: Control and status registers of a multi-channel diode temperature sensor
// Assumes: Two-wire bus pins and diode fault comparators are asynchronous
// Notes: Byte write = address, command, data; read = address(R) after command set
`timescale 1ns/1ns
`default_nettype none
module tsc_ctrl_status #(
	parameter int PWRUP_LIMIT = tsc_pkg::PWRUP_CYCLES
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Two-wire bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// Diode fault comparators
	input wire logic [3:0] i_dplus_short,
	input wire logic [3:0] i_dplus_open,
	// Channel enables and comparator status
	input wire logic [4:0] i_chan_enable,
	input wire logic [4:0] i_status_two,
	input wire logic [4:0] i_status_three,
	input wire logic [4:0] i_status_four,
	input wire logic [4:0] i_mask_two,
	input wire logic [4:0] i_mask_three,
	input wire logic [4:0] i_mask_four,
	// Raw readings, four remotes of 8 bits
	input wire logic [31:0] i_raw_unsigned,
	input wire logic [31:0] i_raw_signed,
	// Outputs
	output logic [1:0] o_remote_one_filter_sel,
	output logic [1:0] o_remote_two_filter_sel,
	output logic o_sleep_control_bit,
	output logic o_busy,
	output logic o_critical_output_one,
	output logic o_critical_output_two,
	output logic o_critical_output_three,
	output logic [31:0] o_reported_unsigned,
	output logic [31:0] o_reported_signed
);
	import tsc_pkg::*;

	localparam logic [21:0] PWRUP_END = 22'(PWRUP_LIMIT);

	tsc_conv_if conv ();
	tsc_conv_seq u_seq (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.conv(conv)
	);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic [3:0] short_m, short_s, open_m, open_s;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			{scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
			{short_m, short_s, open_m, open_s} <= 16'h0000;
		end else begin
			{scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {i_sda, sda_m, sda_s};
			{short_m, short_s} <= {i_dplus_short, short_m};
			{open_m, open_s} <= {i_dplus_open, open_m};
		end
	end
	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & ~sda_s & sda_d;
	assign bus_stop = scl_s & scl_d & sda_s & ~sda_d;

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] filter_reg, config_reg, fault_reg, common_status;
	logic [4:0] stat_two, stat_three, stat_four;
	logic power_up_pending;
	logic [21:0] pwr_cnt;
	logic wr_pulse;
	logic [7:0] wr_cmd, wr_data;
	logic status_four_any, status_three_any, status_two_any, status_one_any;

	assign status_four_any = |stat_four;
	assign status_three_any = |stat_three;
	assign status_two_any = |stat_two;
	assign status_one_any = |fault_reg;
	assign common_status = {conv.busy, power_up_pending, 2'b00, status_four_any,
		status_three_any, status_two_any, status_one_any};

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pwr_cnt <= 22'h000000;
			power_up_pending <= 1'b1;
		end else if (pwr_cnt != PWRUP_END) begin
			pwr_cnt <= pwr_cnt + 22'h000001;
			power_up_pending <= (pwr_cnt != PWRUP_END - 22'h000001);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			filter_reg <= FILTER_RESET;
			config_reg <= CONFIG_RESET;
		end else if (wr_pulse && wr_cmd == CMD_FILTER) begin
			filter_reg <= wr_data & FILTER_WR_MASK;
		end else if (wr_pulse && wr_cmd == CMD_CONFIG) begin
			config_reg <= wr_data & CONFIG_WR_MASK;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			fault_reg <= 8'h00;
			{stat_two, stat_three, stat_four} <= 15'h0000;
		end else begin
			fault_reg <= {open_s[3], short_s[3], open_s[2], short_s[2],
				open_s[1], short_s[1], open_s[0], short_s[0]};
			{stat_two, stat_three, stat_four} <= {i_status_two, i_status_three, i_status_four};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion control
	logic standby;
	assign standby = config_reg[CFG_STANDBY_BIT];
	assign conv.enable = i_chan_enable;
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			conv.start <= 1'b0;
		end else begin
			conv.start <= !power_up_pending && !conv.busy && !conv.start &&
				(standby ? (wr_pulse && wr_cmd == CMD_SINGLE_CONV) : 1'b1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_remote_one_filter_sel <= FILTER_RESET[FLT_R1_LSB +: 2];
			o_remote_two_filter_sel <= FILTER_RESET[FLT_R2_LSB +: 2];
			o_sleep_control_bit <= CONFIG_RESET[CFG_STANDBY_BIT];
			o_busy <= 1'b0;
			o_critical_output_one <= 1'b0;
			o_critical_output_two <= 1'b0;
			o_critical_output_three <= 1'b0;
		end else begin
			o_remote_one_filter_sel <= filter_reg[FLT_R1_LSB +: 2];
			o_remote_two_filter_sel <= filter_reg[FLT_R2_LSB +: 2];
			o_sleep_control_bit <= standby;
			o_busy <= conv.busy;
			o_critical_output_one <= |(stat_two & ~i_mask_two);
			o_critical_output_two <= |(stat_three & ~i_mask_three);
			o_critical_output_three <= |(stat_four & ~i_mask_four);
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sub
			always_ff @(posedge i_clk) begin
				if (i_srst) begin
					o_reported_unsigned[8*g +: 8] <= FAULT_UNSIGNED;
					o_reported_signed[8*g +: 8] <= FAULT_SIGNED;
				end else if (fault_reg[2*g] || fault_reg[2*g+1]) begin
					o_reported_unsigned[8*g +: 8] <= FAULT_UNSIGNED;
					o_reported_signed[8*g +: 8] <= FAULT_SIGNED;
				end else begin
					o_reported_unsigned[8*g +: 8] <= i_raw_unsigned[8*g +: 8];
					o_reported_signed[8*g +: 8] <= i_raw_signed[8*g +: 8];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Two-wire bus slave
	tsc_bus_state_e bstate;
	logic [7:0] shreg, txreg, pointer, rd_byte;
	logic [3:0] bitcnt;
	logic rnw, nack;

	always_comb begin
		case (pointer)
			CMD_COMMON_STATUS: rd_byte = common_status;
			CMD_CONFIG: rd_byte = config_reg;
			CMD_FILTER: rd_byte = filter_reg;
			CMD_FAULT: rd_byte = fault_reg;
			CMD_STATUS_TWO: rd_byte = {3'b000, stat_two};
			CMD_STATUS_THREE: rd_byte = {3'b000, stat_three};
			CMD_STATUS_FOUR: rd_byte = {3'b000, stat_four};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			bstate <= BUS_IDLE;
			{shreg, txreg, pointer, wr_cmd, wr_data} <= 40'h0000000000;
			bitcnt <= 4'h0;
			{rnw, nack, wr_pulse, o_sda_oe, o_sda_out} <= 5'h00;
		end else begin
			wr_pulse <= 1'b0;
			o_sda_out <= 1'b0;
			if (bus_start) begin
				bstate <= BUS_ADDR;
				bitcnt <= 4'h0;
				o_sda_oe <= 1'b0;
			end else if (bus_stop) begin
				bstate <= BUS_IDLE;
				o_sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (bstate == BUS_ADDR || bstate == BUS_CMD || bstate == BUS_WDATA) begin
					shreg <= {shreg[6:0], sda_s};
					bitcnt <= bitcnt + 4'h1;
				end
				if (bstate == BUS_RDATA_ACK) begin
					nack <= sda_s;
				end
			end else if (scl_fall) begin
				case (bstate)
					BUS_ADDR: begin
						if (bitcnt == 4'h8) begin
							if (shreg[7:1] == DEV_ADDR) begin
								o_sda_oe <= 1'b1;
								rnw <= shreg[0];
								bstate <= BUS_ADDR_ACK;
							end else begin
								bstate <= BUS_IDLE;
							end
						end
					end
					BUS_ADDR_ACK, BUS_RDATA_ACK: begin
						bitcnt <= 4'h1;
						if (bstate == BUS_RDATA_ACK && nack) begin
							o_sda_oe <= 1'b0;
							bstate <= BUS_IDLE;
						end else if (rnw) begin
							o_sda_oe <= ~rd_byte[7];
							txreg <= {rd_byte[6:0], 1'b0};
							bstate <= BUS_RDATA;
						end else begin
							o_sda_oe <= 1'b0;
							bitcnt <= 4'h0;
							bstate <= BUS_CMD;
						end
					end
					BUS_CMD, BUS_WDATA: begin
						if (bitcnt == 4'h8) begin
							o_sda_oe <= 1'b1;
							if (bstate == BUS_CMD) begin
								pointer <= shreg;
								bstate <= BUS_CMD_ACK;
							end else begin
								wr_cmd <= pointer;
								wr_data <= shreg;
								wr_pulse <= 1'b1;
								bstate <= BUS_WDATA_ACK;
							end
						end
					end
					BUS_CMD_ACK, BUS_WDATA_ACK: begin
						o_sda_oe <= 1'b0;
						bitcnt <= 4'h0;
						bstate <= BUS_WDATA;
					end
					BUS_RDATA: begin
						if (bitcnt == 4'h8) begin
							o_sda_oe <= 1'b0;
							bstate <= BUS_RDATA_ACK;
						end else begin
							o_sda_oe <= ~txreg[7];
							txreg <= {txreg[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end
					default: begin
						o_sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_filter_upper_zero: assert property (@(posedge i_clk) disable iff (i_srst)
		filter_reg[7:4] == 4'h0 && (pointer != CMD_FILTER || rd_byte[7:4] == 4'h0))
		else $error("filter upper bits not zero");
	chk_filter_write: assert property (@(posedge i_clk) disable iff (i_srst)
		(wr_pulse && wr_cmd == CMD_FILTER) |=> ##1 o_remote_two_filter_sel == $past(wr_data[3:2], 2)
		&& o_remote_one_filter_sel == $past(wr_data[1:0], 2))
		else $error("filter select not taken from write");
	chk_single_start: assert property (@(posedge i_clk) disable iff (i_srst)
		(wr_pulse && wr_cmd == CMD_SINGLE_CONV && standby && !conv.busy && !conv.start
		&& !power_up_pending) |=> conv.start ##1 conv.busy)
		else $error("single conversion not started");
	chk_standby_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
		(conv.start && standby) |-> $past(wr_pulse) && $past(wr_cmd) == CMD_SINGLE_CONV)
		else $error("conversion started in standby without trigger");
	chk_busy_bit: assert property (@(posedge i_clk) disable iff (i_srst)
		(common_status[CS_BUSY_BIT] == conv.busy) and (conv.busy |=> o_busy))
		else $error("busy bit mismatch");
	chk_pending_release: assert property (@(posedge i_clk) disable iff (i_srst)
		$fell(power_up_pending) |-> $past(pwr_cnt) == PWRUP_END - 22'h000001)
		else $error("power-up pending released at wrong count");
	chk_summary_or: assert property (@(posedge i_clk) disable iff (i_srst)
		common_status[3:0] == {|stat_four, |stat_three, |stat_two, |fault_reg}
		&& common_status[5:4] == 2'b00)
		else $error("status summary wrong");
	chk_fault_map: assert property (@(posedge i_clk) disable iff (i_srst)
		fault_reg[7] == $past(open_s[3]) && fault_reg[0] == $past(short_s[0]))
		else $error("fault flag placement wrong");
	chk_fault_subst: assert property (@(posedge i_clk) disable iff (i_srst)
		(fault_reg[1:0] != 2'b00) |=> o_reported_signed[7:0] == FAULT_SIGNED
		&& o_reported_unsigned[7:0] == FAULT_UNSIGNED)
		else $error("fault substitute not reported");
	chk_crit_one: assert property (@(posedge i_clk) disable iff (i_srst)
		o_critical_output_one == $past(|(stat_two & ~i_mask_two)))
		else $error("critical output one wrong");
	cov_single_pass: cover property (@(posedge i_clk) disable iff (i_srst)
		(standby && wr_pulse && wr_cmd == CMD_SINGLE_CONV) ##[1:400] conv.done);
	cov_read_done: cover property (@(posedge i_clk) disable iff (i_srst)
		bstate == BUS_RDATA_ACK ##[1:200] bstate == BUS_IDLE);
	cov_fault: cover property (@(posedge i_clk) disable iff (i_srst) status_one_any);
endmodule
`default_nettype wire

// ==== verification/tsc_host_model.sv ====
// Purpose: Two-wire bus host model driving the sensor's register port
// Assumes: Pull-up on the data line; bus clock of 125 ns, stopped between frames
// Notes: Byte tasks are MSB first; reads end with NACK then STOP
`timescale 1ns/1ns
`default_nettype none
module tsc_host_model
	import tsc_pkg::*;
(
	// Device data driver
	input wire logic i_sda_oe,
	input wire logic i_sda_out,
	// Bus pins
	output logic o_scl,
	output logic o_sda
);
	logic host_low = 1'b0;
	initial o_scl = 1'b1;
	// Open-drain line with pull-up
	assign o_sda = (host_low || (i_sda_oe && !i_sda_out)) ? 1'b0 : 1'b1;
	////////////////////////////////////////////////////////////////////////
	// Bit level
	task automatic bit_io(input logic b, output logic s);
		o_scl = 1'b0;
		#31 host_low = !b;
		#31 o_scl = 1'b1;
		#31 s = o_sda;
		#32;
	endtask
	task automatic start_cond;
		o_scl = 1'b0;
		#31 host_low = 1'b0;
		#31 o_scl = 1'b1;
		#31 host_low = 1'b1;
		#31;
	endtask
	task automatic stop_cond;
		o_scl = 1'b0;
		#31 host_low = 1'b1;
		#31 o_scl = 1'b1;
		#31 host_low = 1'b0;
		#31;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Byte level
	task automatic byte_out(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
	endtask
	task automatic byte_in(output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(1'b1, s);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Register access
	task automatic write_reg(input logic [7:0] cmd, input logic [7:0] d);
		start_cond();
		byte_out({DEV_ADDR, 1'b0});
		byte_out(cmd);
		byte_out(d);
		stop_cond();
	endtask
	task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d);
		start_cond();
		byte_out({DEV_ADDR, 1'b0});
		byte_out(cmd);
		start_cond();
		byte_out({DEV_ADDR, 1'b1});
		byte_in(d);
		stop_cond();
	endtask
endmodule
`default_nettype wire

// ==== verification/thermal_sensor_ctrl_status_bench.sv ====
// Purpose: Self-checking bench of the control/status register block
// Assumes: Host model on the bus, diode comparators driven directly
// Notes: Power-up count shortened to 4000 cycles
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module thermal_sensor_ctrl_status_bench;
	import tsc_pkg::*;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_scl, i_sda, o_sda_out, o_sda_oe;
	logic [3:0] i_dplus_short = 4'h0;
	logic [3:0] i_dplus_open = 4'h0;
	logic [4:0] i_chan_enable = 5'h1f;
	logic [4:0] i_status_two = 5'h00, i_status_three = 5'h00, i_status_four = 5'h00;
	logic [4:0] i_mask_two = 5'h00, i_mask_three = 5'h00, i_mask_four = 5'h00;
	logic [31:0] i_raw_unsigned = 32'h44332211;
	logic [31:0] i_raw_signed = 32'h44332211;
	logic [1:0] o_remote_one_filter_sel, o_remote_two_filter_sel;
	logic o_sleep_control_bit, o_busy;
	logic o_critical_output_one, o_critical_output_two, o_critical_output_three;
	logic [31:0] o_reported_unsigned, o_reported_signed;
	int miscompares = 0;
	int checks_done = 0;
	int busy_cycles = 0;
	logic [1:0] codes [3] = '{2'b00, 2'b01, 2'b11};
	int pass_len [2] = '{131, 320};
	logic [4:0] pass_en [2] = '{5'h11, 5'h1f};
	always #5 i_clk = !i_clk;
	always @(posedge i_clk) if (o_busy === 1'b1) busy_cycles++;
	////////////////////////////////////////////////////////////////////////
	// Instances
	tsc_ctrl_status #(.PWRUP_LIMIT(4000)) tsc_ctrl_status_i (
		.i_clk(i_clk), .i_srst(i_srst), .i_scl(i_scl), .i_sda(i_sda),
		.o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
		.i_dplus_short(i_dplus_short), .i_dplus_open(i_dplus_open),
		.i_chan_enable(i_chan_enable), .i_status_two(i_status_two),
		.i_status_three(i_status_three), .i_status_four(i_status_four),
		.i_mask_two(i_mask_two), .i_mask_three(i_mask_three), .i_mask_four(i_mask_four),
		.i_raw_unsigned(i_raw_unsigned), .i_raw_signed(i_raw_signed),
		.o_remote_one_filter_sel(o_remote_one_filter_sel),
		.o_remote_two_filter_sel(o_remote_two_filter_sel),
		.o_sleep_control_bit(o_sleep_control_bit), .o_busy(o_busy),
		.o_critical_output_one(o_critical_output_one),
		.o_critical_output_two(o_critical_output_two),
		.o_critical_output_three(o_critical_output_three),
		.o_reported_unsigned(o_reported_unsigned), .o_reported_signed(o_reported_signed)
	);
	tsc_host_model tsc_host_model_i (
		.i_sda_oe(o_sda_oe), .i_sda_out(o_sda_out), .o_scl(i_scl), .o_sda(i_sda)
	);
	////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic tally_and_finish;
		if (miscompares == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
		tsc_host_model_i.write_reg(cmd, d);
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] got;
		tsc_host_model_i.read_reg(cmd, got);
		`CHK(got, exp)
	endtask
	task automatic fault_case(input logic [14:0] st, input logic [14:0] mk,
		input logic [3:0] sh, input logic [3:0] op, input logic [2:0] crit,
		input logic [7:0] flt, input logic [7:0] cs, input logic [31:0] ru,
		input logic [31:0] rs);
		@(negedge i_clk);
		{i_status_four, i_status_three, i_status_two} = st;
		{i_mask_four, i_mask_three, i_mask_two} = mk;
		i_dplus_short = sh;
		i_dplus_open = op;
		repeat (10) @(negedge i_clk);
		`CHK(o_reported_unsigned, ru)
		`CHK(o_reported_signed, rs)
		`CHK({o_critical_output_three, o_critical_output_two, o_critical_output_one}, crit)
		rd(CMD_FAULT, flt);
		rd(CMD_COMMON_STATUS, cs);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#600000;
		miscompares++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////
	// Tests
	initial begin
		repeat (6) @(negedge i_clk);
		i_srst = 1'b0;
		repeat (8) @(negedge i_clk);
		`CHK(o_remote_one_filter_sel, 2'b11)
		`CHK(o_remote_two_filter_sel, 2'b11)
		`CHK(o_sleep_control_bit, 1'b0)
		rd(CMD_COMMON_STATUS, 8'h40);
		wr(CMD_COMMON_STATUS, 8'hff);
		wr(CMD_CONFIG, 8'h43);
		`CHK(o_sleep_control_bit, 1'b1)
		rd(CMD_COMMON_STATUS, 8'h40);
		rd(CMD_FILTER, 8'h0f);
		// Only the documented filter codes are written
		for (int k = 0; k < 3; k++) begin
			wr(CMD_FILTER, {4'hf, codes[(k + 1) % 3], codes[k]});
			rd(CMD_FILTER, {4'h0, codes[(k + 1) % 3], codes[k]});
			`CHK(o_remote_one_filter_sel, codes[k])
			`CHK(o_remote_two_filter_sel, codes[(k + 1) % 3])
		end
		repeat (500) @(negedge i_clk);
		rd(CMD_COMMON_STATUS, 8'h00);
		`CHK(busy_cycles, 0)
		for (int k = 0; k < 2; k++) begin
			@(negedge i_clk);
			i_chan_enable = pass_en[k];
			busy_cycles = 0;
			wr(CMD_SINGLE_CONV, 8'ha5);
			for (int n = 0; n < 1000 && o_busy !== 1'b0; n++) @(negedge i_clk);
			repeat (400) @(negedge i_clk);
			`CHK(busy_cycles, pass_len[k])
		end
		rd(CMD_SINGLE_CONV, 8'h00);
		fault_case(15'h4001, 15'h0000, 4'h1, 4'h8, 3'b101, 8'h81, 8'h0b,
			32'h00332200, 32'h80332280);
		fault_case(15'h4082, 15'h4002, 4'h4, 4'h2, 3'b010, 8'h18, 8'h0f,
			32'h44000011, 32'h44808011);
		fault_case(15'h0000, 15'h0000, 4'h0, 4'h0, 3'b000, 8'h00, 8'h00,
			32'h44332211, 32'h44332211);
		// Leaving standby starts back-to-back passes
		wr(CMD_CONFIG, 8'h03);
		`CHK(o_sleep_control_bit, 1'b0)
		busy_cycles = 0;
		repeat (700) @(negedge i_clk);
		`CHK(busy_cycles >= 690, 1'b1)
		tally_and_finish();
	end
endmodule
`default_nettype wire
